// File: design/din_pkg.sv
package din_pkg;

  // bus geometry
  localparam int ADR_W  = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CHANNEL_FUNCTION = 6'h01;
  localparam logic [IDX_W-1:0] IDX_CONFIG_ONE       = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CONFIG_TWO       = 6'h05;
  localparam logic [IDX_W-1:0] IDX_INPUT_COUNT      = 6'h10;
  localparam logic [IDX_W-1:0] IDX_INPUT_STATUS     = 6'h11;

  // reset values and writable masks
  localparam logic [REG_W-1:0] CONFIG_ONE_RESET = 16'h000B;
  localparam logic [REG_W-1:0] CONFIG_TWO_RESET = 16'h0000;
  localparam logic [REG_W-1:0] CONFIG_ONE_WMASK = 16'hFFDF;
  localparam logic [REG_W-1:0] CONFIG_TWO_WMASK = 16'h07FF;

  // first configuration register fields
  localparam int CFG1_COUNT_EN = 15;
  localparam int CFG1_INVERT   = 14;
  localparam int CFG1_COMP_EN  = 13;
  localparam int CFG1_RANGE    = 12;
  localparam int CFG1_SINK_LSB = 7;
  localparam int CFG1_SINK_W   = 5;
  localparam int CFG1_METHOD   = 6;
  localparam int CFG1_DEB_LSB  = 0;
  localparam int CFG1_DEB_W    = 5;

  // second configuration register fields
  localparam int CFG2_UNBUF   = 10;
  localparam int CFG2_SHORT   = 9;
  localparam int CFG2_OPEN    = 8;
  localparam int CFG2_THR_REF = 7;
  localparam int CFG2_THR_LSB = 0;
  localparam int CFG2_THR_W   = 7;

  // status register fields
  localparam int STAT_DEBOUNCED   = 0;
  localparam int STAT_CONDITIONED = 1;

  // sink current scaling, in microamps
  localparam int                    SINK_CUR_W       = 13;
  localparam logic [SINK_CUR_W-1:0] SINK_STEP_LOW_UA  = 13'h0078;
  localparam logic [SINK_CUR_W-1:0] SINK_STEP_HIGH_UA = 13'h00F0;

  // debounce timing
  localparam int                    CLK_MHZ              = 50;
  localparam int                    DEBOUNCE_REF_TIME_US = 240;
  localparam logic [CFG1_DEB_W-1:0] DEBOUNCE_REF_CODE    = 5'h0B;
  localparam logic [CFG1_DEB_W-1:0] DEBOUNCE_BYPASS_CODE = 5'h00;

  // channel function codes
  localparam int                FUNC_W             = 4;
  localparam logic [FUNC_W-1:0] FUNC_RESET         = 4'h0;
  localparam logic [FUNC_W-1:0] FUNC_DIGITAL_INPUT = 4'h8;

endpackage

// File: design/debounce_filter.sv
`timescale 1ns/1ns

module debounce_filter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             method_i,
  input  wire logic             bypass_i,
  input  wire logic [CNT_W-1:0] duration_i,
  // signal
  input  wire logic             sample_i,
  output logic                  filtered_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  assign next_count = count + CNT_W'(1);

  // counter tracks how long the input has disagreed with the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count      <= '0;
      filtered_o <= 1'b0;
    end else if (bypass_i) begin
      count      <= '0;
      filtered_o <= sample_i;
    end else if (sample_i != filtered_o) begin
      if (next_count >= duration_i) begin
        count      <= '0;
        filtered_o <= sample_i;
      end else begin
        count <= next_count;
      end
    end else if (method_i) begin
      count <= '0;
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

endmodule

// File: design/digital_input_config.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns

//Contract
// - count rising debounced edges when not inverted
// - count falling debounced edges when inverted
// - edge count readable in count register
// - inversion bit inverts comparator output
// - comparator enable bit; function write changes it
// - method zero: integrating up/down counter
// - method one: counter clears on deassert
// - five-bit debounce time, reset 240 us
// - debounce code zero bypasses filter
// - sink level times range; zero is off
// - function register write clears sink level
// - range selects 120 or 240 uA step
// - threshold reference: supply-scaled or fixed
// - seven-bit threshold code drives comparator
// - short detect enable bit
// - open detect enable bit
// - unbuffered input enable bit
module digital_input_config
  import din_pkg::*;
#(
  parameter int DEBOUNCE_REF_CYCLES = din_pkg::DEBOUNCE_REF_TIME_US * din_pkg::CLK_MHZ,
  parameter int FILTER_CNT_W        = 16,
  parameter int COUNT_W             = 16
) (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  // wishbone slave
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [din_pkg::ADR_W-1:0]          wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [din_pkg::DATA_W-1:0]         wb_dat_i,
  output logic      [din_pkg::DATA_W-1:0]         wb_dat_o,
  output logic                                    wb_ack_o,
  // field comparator
  input  wire logic                               comparator_i,
  output logic                                    comparator_enable_o,
  output logic                                    threshold_reference_select_o,
  output logic      [din_pkg::CFG2_THR_W-1:0]     threshold_code_o,
  // current sink
  output logic                                    sink_range_o,
  output logic      [din_pkg::CFG1_SINK_W-1:0]    sink_level_o,
  output logic      [din_pkg::SINK_CUR_W-1:0]     sink_current_ua_o,
  // diagnostics and path
  output logic                                    short_detect_enable_o,
  output logic                                    open_detect_enable_o,
  output logic                                    unbuffered_input_enable_o,
  // filtered input
  output logic                                    digital_input_o,
  output logic      [COUNT_W-1:0]                 input_count_o
);

  import din_pkg::*;

  logic [REG_W-1:0]        input_config_one;
  logic [REG_W-1:0]        input_config_two;
  logic [FUNC_W-1:0]       channel_function_select;
  logic [COUNT_W-1:0]      input_count;

  logic [IDX_W-1:0]        bus_index;
  logic                    bus_request;
  logic                    bus_write;
  logic [REG_W-1:0]        byte_mask;
  logic [REG_W-1:0]        write_data;

  logic                    conditioned;
  logic                    debounced;
  logic                    debounced_prev;
  logic                    edge_seen;
  logic [FILTER_CNT_W-1:0] duration;
  logic [FILTER_CNT_W-1:0] next_duration;
  logic                    bypass;
  logic [DATA_W-1:0]       next_read_data;

  // bus decode
  assign bus_index   = wb_adr_i[ADR_W-1:2];
  assign bus_request = wb_cyc_i & wb_stb_i;
  assign bus_write   = bus_request & wb_we_i & wb_ack_o;
  assign byte_mask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign write_data  = wb_dat_i[REG_W-1:0];

  // one ack per request, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_request & ~wb_ack_o;
    end
  end

  // read data sampled together with the ack
  always_comb begin
    next_read_data = '0;
    case (bus_index)
      IDX_CHANNEL_FUNCTION: next_read_data[FUNC_W-1:0] = channel_function_select;
      IDX_CONFIG_ONE:       next_read_data[REG_W-1:0]  = input_config_one;
      IDX_CONFIG_TWO:       next_read_data[REG_W-1:0]  = input_config_two;
      IDX_INPUT_COUNT:      next_read_data[COUNT_W-1:0] = input_count;
      IDX_INPUT_STATUS: begin
        next_read_data[STAT_DEBOUNCED]   = debounced;
        next_read_data[STAT_CONDITIONED] = conditioned;
      end
      default:              next_read_data = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_request & ~wb_ack_o) begin
      wb_dat_o <= next_read_data;
    end
  end

  // channel function select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_function_select <= FUNC_RESET;
    end else if (bus_write && bus_index == IDX_CHANNEL_FUNCTION && wb_sel_i[0]) begin
      channel_function_select <= write_data[FUNC_W-1:0];
    end
  end

  // first configuration register, also touched by function writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_config_one <= CONFIG_ONE_RESET;
    end else if (bus_write && bus_index == IDX_CONFIG_ONE) begin
      input_config_one <= (input_config_one & ~(byte_mask & CONFIG_ONE_WMASK))
                        | (write_data & byte_mask & CONFIG_ONE_WMASK);
    end else if (bus_write && bus_index == IDX_CHANNEL_FUNCTION && wb_sel_i[0]) begin
      input_config_one[CFG1_SINK_LSB +: CFG1_SINK_W] <= '0;
      input_config_one[CFG1_COMP_EN] <= (write_data[FUNC_W-1:0] == FUNC_DIGITAL_INPUT);
    end
  end

  // second configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_config_two <= CONFIG_TWO_RESET;
    end else if (bus_write && bus_index == IDX_CONFIG_TWO) begin
      input_config_two <= (input_config_two & ~(byte_mask & CONFIG_TWO_WMASK))
                        | (write_data & byte_mask & CONFIG_TWO_WMASK);
    end
  end

  // comparator result, inverted on request and gated by enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conditioned <= 1'b0;
    end else begin
      conditioned <= input_config_one[CFG1_COMP_EN]
                   & (comparator_i ^ input_config_one[CFG1_INVERT]);
    end
  end

  // debounce duration scales linearly through the reference code
  assign next_duration = FILTER_CNT_W'(
    (int'(input_config_one[CFG1_DEB_LSB +: CFG1_DEB_W]) * DEBOUNCE_REF_CYCLES)
    / int'(DEBOUNCE_REF_CODE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duration <= '0;
      bypass   <= 1'b1;
    end else begin
      duration <= next_duration;
      bypass   <= (input_config_one[CFG1_DEB_LSB +: CFG1_DEB_W] == DEBOUNCE_BYPASS_CODE);
    end
  end

  debounce_filter #(
    .CNT_W      (FILTER_CNT_W)
  ) filter (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .method_i   (input_config_one[CFG1_METHOD]),
    .bypass_i   (bypass),
    .duration_i (duration),
    .sample_i   (conditioned),
    .filtered_o (debounced)
  );

  // edge counter; an edge in the clearing cycle still counts
  always_comb begin
    if (input_config_one[CFG1_INVERT]) begin
      edge_seen = input_config_one[CFG1_COUNT_EN] & debounced_prev & ~debounced;
    end else begin
      edge_seen = input_config_one[CFG1_COUNT_EN] & ~debounced_prev & debounced;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debounced_prev <= 1'b0;
    end else begin
      debounced_prev <= debounced;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_count <= '0;
    end else if (bus_write && bus_index == IDX_INPUT_COUNT) begin
      input_count <= edge_seen ? COUNT_W'(1) : '0;
    end else if (edge_seen) begin
      input_count <= input_count + COUNT_W'(1);
    end
  end

  // analog-facing controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_enable_o          <= 1'b0;
      threshold_reference_select_o <= 1'b0;
      threshold_code_o             <= '0;
      sink_range_o                 <= 1'b0;
      sink_level_o                 <= '0;
      sink_current_ua_o            <= '0;
    end else begin
      comparator_enable_o          <= input_config_one[CFG1_COMP_EN];
      threshold_reference_select_o <= input_config_two[CFG2_THR_REF];
      threshold_code_o             <= input_config_two[CFG2_THR_LSB +: CFG2_THR_W];
      sink_range_o                 <= input_config_one[CFG1_RANGE];
      sink_level_o                 <= input_config_one[CFG1_SINK_LSB +: CFG1_SINK_W];
      sink_current_ua_o            <= SINK_CUR_W'(input_config_one[CFG1_SINK_LSB +: CFG1_SINK_W])
                                    * (input_config_one[CFG1_RANGE] ? SINK_STEP_HIGH_UA
                                                                    : SINK_STEP_LOW_UA);
    end
  end

  // diagnostics, path select and results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_detect_enable_o     <= 1'b0;
      open_detect_enable_o      <= 1'b0;
      unbuffered_input_enable_o <= 1'b0;
      digital_input_o           <= 1'b0;
      input_count_o             <= '0;
    end else begin
      short_detect_enable_o     <= input_config_two[CFG2_SHORT];
      open_detect_enable_o      <= input_config_two[CFG2_OPEN];
      unbuffered_input_enable_o <= input_config_two[CFG2_UNBUF];
      digital_input_o           <= debounced;
      input_count_o             <= input_count;
    end
  end

endmodule

// File: tb/digital_input_config_props.sv
`timescale 1ns/1ns
module digital_input_config_props
  import din_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // bus
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [din_pkg::DATA_W-1:0]   wb_dat_o,
  input wire logic                         wb_ack_o,
  // outputs
  input wire logic                         comparator_enable_o,
  input wire logic                         sink_range_o,
  input wire logic [din_pkg::CFG1_SINK_W-1:0] sink_level_o,
  input wire logic [din_pkg::SINK_CUR_W-1:0]  sink_current_ua_o,
  input wire logic                         digital_input_o,
  input wire logic [COUNT_W-1:0]           input_count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  data_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  sink_scale_a: assert property (sink_current_ua_o ==
    {8'h00, sink_level_o} * (sink_range_o ? SINK_STEP_HIGH_UA : SINK_STEP_LOW_UA))
    else $error("sink current not level times step");
  count_step_a: assert property ($changed(input_count_o) |->
    input_count_o == $past(input_count_o) + 1'b1 || input_count_o <= 1)
    else $error("edge count jumped");
  count_edge_a: assert property (input_count_o == $past(input_count_o) + 1'b1 && input_count_o > 1 |->
    $past(digital_input_o) != $past(digital_input_o, 2))
    else $error("count without debounced edge");
  config_cause_a: assert property ($changed(comparator_enable_o) || $changed(sink_level_o) |->
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("config output moved without write");

  cover property ($rose(comparator_enable_o));
  cover property (input_count_o == 16'h0003);
  cover property ($rose(digital_input_o));
endmodule

// File: tb/field_input_model.sv
`timescale 1ns/1ns
module field_input_model (
  // clock
  input  wire logic clk_i,
  // requested field level
  input  wire logic level_i,
  // comparator result
  output logic      comparator_o
);
  // terminal settles one cycle after a level change
  always_ff @(posedge clk_i) begin
    comparator_o <= level_i;
  end
endmodule

// File: tb/digital_input_config_tb.sv
`timescale 1ns/1ns
module digital_input_config_tb;
  import din_pkg::*;
  logic              clk_i;
  logic              rst_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic              wb_ack_o;
  logic              level;
  logic              comparator_i;
  logic [ADR_W-1:0]  wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i;
  logic [DATA_W-1:0] wb_dat_o;
  logic [DATA_W-1:0] rd;
  logic              comparator_enable_o;
  logic              threshold_reference_select_o;
  logic [6:0]        threshold_code_o;
  logic              sink_range_o;
  logic [4:0]        sink_level_o;
  logic [12:0]       sink_current_ua_o;
  logic              short_detect_enable_o;
  logic              open_detect_enable_o;
  logic              unbuffered_input_enable_o;
  logic              digital_input_o;
  logic [15:0]       input_count_o;
  int                num_errors;
  int                compares;

  digital_input_config #(.DEBOUNCE_REF_CYCLES(22)) dut (.*);
  field_input_model u_field (.clk_i(clk_i), .level_i(level), .comparator_o(comparator_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic hold(input logic v, input int n);
    level <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_reset();
    bus(1'b0, 8'h10, 32'h0); check(rd, 32'h0000000B);
    bus(1'b0, 8'h14, 32'h0); check(rd, 32'h0);
    bus(1'b1, 8'h20, 32'hFFFF);
    bus(1'b0, 8'h20, 32'h0); check(rd, 32'h0);
    check(32'(comparator_enable_o), 32'h0);
    $display("reset test done");
  endtask

  task automatic t_regs();
    bus(1'b1, 8'h14, 32'hFFFF);
    bus(1'b0, 8'h14, 32'h0); check(rd, 32'h07FF);
    check(32'({unbuffered_input_enable_o, short_detect_enable_o, open_detect_enable_o,
      threshold_reference_select_o, threshold_code_o}), 32'h7FF);
    bus(1'b1, 8'h10, 32'h1FFF);
    bus(1'b0, 8'h10, 32'h0); check(rd, 32'h1FDF);
    check(32'(sink_current_ua_o), 32'h1D10);
    bus(1'b1, 8'h04, 32'h8);
    bus(1'b0, 8'h10, 32'h0); check(rd, 32'h305F);
    check(32'(comparator_enable_o), 32'h1);
    bus(1'b1, 8'h10, 32'h0F80);
    hold(1'b0, 2); check(32'(sink_current_ua_o), 32'hE88);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'h10, 32'h0); check(rd, 32'h0);
    check(32'(sink_current_ua_o), 32'h0);
    $display("register test done");
  endtask

  task automatic t_bypass();
    bus(1'b1, 8'h10, 32'hA000);
    hold(1'b0, 4);
    bus(1'b1, 8'h40, 32'h0);
    repeat (3) begin
      hold(1'b1, 4);
      hold(1'b0, 4);
    end
    bus(1'b0, 8'h40, 32'h0); check(rd, 32'h3);
    hold(1'b1, 6); check(32'(digital_input_o), 32'h1);
    bus(1'b0, 8'h44, 32'h0); check(rd, 32'h3);
    hold(1'b0, 6);
    bus(1'b1, 8'h10, 32'hE000);
    hold(1'b0, 6); check(32'(digital_input_o), 32'h1);
    bus(1'b1, 8'h40, 32'h0);
    repeat (2) begin
      hold(1'b1, 4);
      hold(1'b0, 4);
    end
    bus(1'b0, 8'h40, 32'h0); check(rd, 32'h2);
    check(32'(input_count_o), 32'h2);
    $display("bypass and count test done");
  endtask

  // a one-cycle dropout splits two long high stretches
  task automatic t_filter(input logic method, input logic exp);
    bus(1'b1, 8'h10, method ? 32'hA04B : 32'hA00B);
    hold(1'b0, 40);
    hold(1'b1, 10); check(32'(digital_input_o), 32'h0);
    hold(1'b1, 5);
    hold(1'b0, 1);
    hold(1'b1, 20); check(32'(digital_input_o), 32'(exp));
    hold(1'b1, 10); check(32'(digital_input_o), 32'h1);
    hold(1'b0, 40);
    $display("filter test done");
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = '0;
    wb_dat_i = '0;
    level = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_bypass();
    t_filter(1'b0, 1'b1);
    t_filter(1'b1, 1'b0);
    conclude();
  end
endmodule

bind digital_input_config digital_input_config_props #(.COUNT_W(COUNT_W)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator_enable_o(comparator_enable_o),
  .sink_range_o(sink_range_o), .sink_level_o(sink_level_o), .sink_current_ua_o(sink_current_ua_o),
  .digital_input_o(digital_input_o), .input_count_o(input_count_o));
